// ===== verilog/excmm_regs.svh
// Constants for the exception code and management entry block.
// Assumes inclusion by bare name from the design files.
`ifndef EXCMM_REGS_SVH
`define EXCMM_REGS_SVH
// Exception vectors
`define EXCMM_VEC_DF 8'h08
`define EXCMM_VEC_TS 8'h0a
`define EXCMM_VEC_NP 8'h0b
`define EXCMM_VEC_SS 8'h0c
`define EXCMM_VEC_GP 8'h0d
`define EXCMM_VEC_PF 8'h0e
`define EXCMM_VEC_AC 8'h11
// Error code field positions
`define EXCMM_ERR_IDX_HI 15
`define EXCMM_ERR_IDX_LO 3
`define EXCMM_ERR_CAUSE 2
`define EXCMM_ERR_RW 1
`define EXCMM_ERR_ORIGIN 0
// Configuration bit positions in cfg_ctrl_reg_one
`define EXCMM_CFG_CTRL_REG_ONE_ALLOW 1
`define EXCMM_CFG_CTRL_REG_ONE_CODE 2
// Pin low width needed, in system clock periods
`define EXCMM_PIN_MIN_LOW 2
// Cycles spent saving the header
`define EXCMM_SAVE_CYCLES 4
`endif

// ===== verilog/excmm_pkg.sv
// Types for the exception code and management entry block.
// Assumes no other packages.
package excmm_pkg;
	// Fault classes that shape the error code
	typedef enum logic [1:0]
	{
		EXCMM_FC_PAGE = 2'h0,
		EXCMM_FC_IDT = 2'h1,
		EXCMM_FC_SEG = 2'h2,
		EXCMM_FC_ZERO = 2'h3
	} excmm_fclass_e;
	// Management entry sequencer states
	typedef enum logic [1:0]
	{
		EXCMM_ST_RUN = 2'h0,
		EXCMM_ST_SAVE = 2'h1,
		EXCMM_ST_FETCH = 2'h2,
		EXCMM_ST_MGMT = 2'h3
	} excmm_state_e;
endpackage : excmm_pkg

// ===== verilog/excmm_pin_sync.sv
// Two-stage synchroniser and falling-edge detector for the management pin.
// Assumes the pin is asynchronous to clk_sys.
`include "excmm_regs.svh"
module excmm_pin_sync
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Pin side
	input wire logic mgmt_irq_pin_n,
	// Synchronised view
	output logic pin_low,
	output logic fall_pulse
);
	logic meta_q;
	logic sync_q;
	logic prev_q;
	logic [1:0] low_cnt_q;

	// Synchroniser; first stage read only by second
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end
		else
		begin
			meta_q <= mgmt_irq_pin_n;
			sync_q <= meta_q; // see [RQ23]
		end
	end

	// Low width counter, saturating
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			low_cnt_q <= 2'h0;
		else if (sync_q)
			low_cnt_q <= 2'h0;
		else if (low_cnt_q != 2'h3)
			low_cnt_q <= low_cnt_q + 2'h1;
	end

	// Edge is reported once the low level has lasted the minimum width
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			prev_q <= 1'b0;
			fall_pulse <= 1'b0;
			pin_low <= 1'b0;
		end
		else
		begin
			prev_q <= (low_cnt_q == 2'(`EXCMM_PIN_MIN_LOW - 1)) && !sync_q;
			fall_pulse <= (low_cnt_q == 2'(`EXCMM_PIN_MIN_LOW - 1)) && !sync_q && !prev_q; // see [RQ20]
			pin_low <= !sync_q;
		end
	end
endmodule : excmm_pin_sync

// ===== verilog/excmm_err_code.sv
// Error code former for protected and real mode exceptions.
// Assumes fault details are valid with the request in the same cycle.
`include "excmm_regs.svh"
module excmm_err_code
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Request
	input wire logic exc_req,
	input wire logic [7:0] exc_vector,
	input wire logic real_mode,
	input wire logic [12:0] sel_index,
	input wire logic table_indicator,
	input wire logic in_handler,
	input wire logic pf_protect,
	input wire logic pf_write,
	input wire logic pf_user,
	input wire logic idt_fault,
	// Result
	output logic exc_valid,
	output logic [7:0] exc_vec_out,
	output logic exc_suppressed,
	output logic err_push,
	output logic [15:0] err_code
);
	// Vectors that push a code in protected mode
	function automatic logic pushes(input logic [7:0] v);
		pushes = (v == `EXCMM_VEC_DF) || (v == `EXCMM_VEC_AC) || (v == `EXCMM_VEC_TS)
			|| (v == `EXCMM_VEC_NP) || (v == `EXCMM_VEC_SS) || (v == `EXCMM_VEC_GP)
			|| (v == `EXCMM_VEC_PF);
	endfunction : pushes

	excmm_pkg::excmm_fclass_e fclass;
	logic no_real;
	logic [15:0] code;

	// Class and code selection
	always_comb
	begin
		if (exc_vector == `EXCMM_VEC_PF)
			fclass = excmm_pkg::EXCMM_FC_PAGE;
		else if (exc_vector == `EXCMM_VEC_DF || exc_vector == `EXCMM_VEC_AC)
			fclass = excmm_pkg::EXCMM_FC_ZERO; // see [RQ6]
		else if (idt_fault)
			fclass = excmm_pkg::EXCMM_FC_IDT;
		else
			fclass = excmm_pkg::EXCMM_FC_SEG;
		code = 16'h0000;
		case (fclass)
			excmm_pkg::EXCMM_FC_PAGE:
			begin
				code[`EXCMM_ERR_CAUSE] = pf_protect; // see [RQ7]
				code[`EXCMM_ERR_RW] = pf_write; // see [RQ8]
				code[`EXCMM_ERR_ORIGIN] = pf_user; // see [RQ9]
			end
			excmm_pkg::EXCMM_FC_IDT:
			begin
				code[`EXCMM_ERR_IDX_HI:`EXCMM_ERR_IDX_LO] = sel_index; // see [RQ10]
				code[`EXCMM_ERR_RW] = 1'b1;
				code[`EXCMM_ERR_ORIGIN] = in_handler;
			end
			excmm_pkg::EXCMM_FC_SEG:
			begin
				code[`EXCMM_ERR_IDX_HI:`EXCMM_ERR_IDX_LO] = sel_index; // see [RQ11]
				code[`EXCMM_ERR_CAUSE] = table_indicator;
				code[`EXCMM_ERR_ORIGIN] = in_handler;
			end
			default:
				code = 16'h0000;
		endcase
		no_real = (exc_vector == `EXCMM_VEC_TS) || (exc_vector == `EXCMM_VEC_NP)
			|| (exc_vector == `EXCMM_VEC_PF);
	end

	// Registered result; real mode drops 10, 11, 14 and pushes nothing
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			exc_valid <= 1'b0;
			exc_vec_out <= 8'h00;
			exc_suppressed <= 1'b0;
			err_push <= 1'b0;
			err_code <= 16'h0000;
		end
		else
		begin
			exc_valid <= exc_req && !(real_mode && no_real); // see [RQ1]
			exc_suppressed <= exc_req && real_mode && no_real;
			exc_vec_out <= exc_req ? exc_vector : 8'h00; // see [RQ2] [RQ3]
			err_push <= exc_req && !real_mode && pushes(exc_vector); // see [RQ4] [RQ5]
			err_code <= (exc_req && !real_mode && pushes(exc_vector)) ? code : 16'h0000;
		end
	end
endmodule : excmm_err_code

// ===== verilog/excmm_top.sv
// Exception error codes and management mode entry control.
// Assumes the core pipeline drives request strobes on clk_sys and
// the management pin arrives asynchronously from a companion chipset.
//
// Functional notes
// [RQ1] Real mode never raises vectors 10, 11 or 14.
// [RQ2] Real mode vector 8 means interrupt table limit overrun.
// [RQ3] Real mode vector 12 means stack segment limit overrun.
// [RQ4] Vector 13 pushes code only in protected mode.
// [RQ5] Protected mode DF, AC, TS, NP, SS, GP, PF push 16-bit codes.
// [RQ6] Double fault and alignment check codes are zero.
// [RQ7] Page fault bit 2: 0 not present, 1 protection; 15:3 unused.
// [RQ8] Page fault bit 1: 0 read, 1 write.
// [RQ9] Page fault bit 0: 0 supervisor, 1 user.
// [RQ10] Table fault: index in 15:3, bit 1 set, bit 0 handler origin.
// [RQ11] Segment fault: index 15:3, indicator in bit 2, bit 1 clear.
// [RQ12] Pin management interrupt outranks all others including non-maskable.
// [RQ13] Software trap enters management mode like the pin.
// [RQ14] Selected memory region accesses may raise management interrupts too.
// [RQ15] Outside agent holds pin low at least two clocks.
// [RQ16] Both entries need the allow bit set.
// [RQ17] Pin needs code access bit 0; trap needs it 1.
// [RQ18] Both entries need region size field above zero.
// [RQ19] Entry saves header, then real mode, then fetch from base.
// [RQ20] Each falling pin edge raises a management interrupt; the code counts only edges held low for EXCMM_PIN_MIN_LOW clocks.
// [RQ21] Resume with pin not held low since entry raises new interrupt.
// [RQ22] Chipset makes one falling edge per stored event.
// [RQ23] Pin is synchronised before edge and width logic.
`include "excmm_regs.svh"
module excmm_top
#(
	// Header save length in clk_sys cycles
	parameter int SAVE_CYCLES = `EXCMM_SAVE_CYCLES
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Management pin from chipset
	input wire logic mgmt_irq_pin_n,
	// Configuration bits
	input wire logic [7:0] cfg_ctrl_reg_one,
	input wire logic [3:0] mgmt_region_size_reg,
	// Core event strobes
	input wire logic soft_mgmt_trap_insn,
	input wire logic mgmt_resume_insn,
	input wire logic mem_region_trap,
	input wire logic io_trap,
	input wire logic nmi_req,
	input wire logic intr_req,
	// Exception request
	input wire logic exc_req,
	input wire logic [7:0] exc_vector,
	input wire logic real_mode,
	input wire logic [12:0] sel_index,
	input wire logic table_indicator,
	input wire logic in_handler,
	input wire logic pf_protect,
	input wire logic pf_write,
	input wire logic pf_user,
	input wire logic idt_fault,
	// Exception result
	output logic exc_valid,
	output logic [7:0] exc_vec_out,
	output logic exc_suppressed,
	output logic err_push,
	output logic [15:0] err_code,
	// Interrupt arbitration result
	output logic take_mgmt,
	output logic take_nmi,
	output logic take_intr,
	// Management entry sequence
	output logic hdr_save,
	output logic force_real,
	output logic fetch_base,
	output logic system_mgmt_mode
);
	logic pin_low;
	logic fall_pulse;
	logic pin_ok;
	logic trap_ok;
	logic pend_q;
	logic pend_d;
	logic low_since_q;
	logic [2:0] save_cnt_q;
	logic start;
	excmm_pkg::excmm_state_e state_q;
	excmm_pkg::excmm_state_e state_d;

	// Refuse lengths that the three-bit save counter cannot count
	if (SAVE_CYCLES < 1 || SAVE_CYCLES > 8)
	begin : g_save_range
		$error("excmm_top: SAVE_CYCLES must lie between 1 and 8");
	end

	// The width counter in the synchroniser saturates at three
	if (`EXCMM_PIN_MIN_LOW < 1 || `EXCMM_PIN_MIN_LOW > 4)
	begin : g_pin_range
		$error("excmm_top: pin low width must lie between 1 and 4");
	end

	// Idle sequencer: the only state that accepts entries and interrupts
	function automatic logic is_running(input excmm_pkg::excmm_state_e s);
		is_running = (s == excmm_pkg::EXCMM_ST_RUN);
	endfunction : is_running

	// Shared recognition gate; the two entry kinds differ only in the
	// code access level that they need
	function automatic logic entry_gate(input logic [7:0] cfg, input logic [3:0] size,
		input logic want_code);
		entry_gate = cfg[`EXCMM_CFG_CTRL_REG_ONE_ALLOW] // see [RQ16]
			&& (cfg[`EXCMM_CFG_CTRL_REG_ONE_CODE] == want_code) // see [RQ17]
			&& (size != 4'h0); // see [RQ18]
	endfunction : entry_gate

	excmm_pin_sync u_sync
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.mgmt_irq_pin_n(mgmt_irq_pin_n),
		.pin_low(pin_low),
		.fall_pulse(fall_pulse)
	);

	excmm_err_code u_err
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.exc_req(exc_req),
		.exc_vector(exc_vector),
		.real_mode(real_mode),
		.sel_index(sel_index),
		.table_indicator(table_indicator),
		.in_handler(in_handler),
		.pf_protect(pf_protect),
		.pf_write(pf_write),
		.pf_user(pf_user),
		.idt_fault(idt_fault),
		.exc_valid(exc_valid),
		.exc_vec_out(exc_vec_out),
		.exc_suppressed(exc_suppressed),
		.err_push(err_push),
		.err_code(err_code)
	);

	// Recognition gates: the pin wants code access clear, the trap wants it set
	assign pin_ok = entry_gate(cfg_ctrl_reg_one, mgmt_region_size_reg, 1'b0); // see [RQ17]
	assign trap_ok = entry_gate(cfg_ctrl_reg_one, mgmt_region_size_reg, 1'b1); // see [RQ17]

	// Pending request: edges, region and io traps, and resume re-raise
	always_comb
	begin
		pend_d = pend_q;
		if (start)
			pend_d = 1'b0;
		if (pin_ok && fall_pulse) // see [RQ20] [RQ15]
			pend_d = 1'b1;
		if (pin_ok && (mem_region_trap || io_trap)) // see [RQ14]
			pend_d = 1'b1;
		if (pin_ok && mgmt_resume_insn && system_mgmt_mode && !low_since_q) // see [RQ21]
			pend_d = 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			pend_q <= 1'b0;
		else
			pend_q <= pend_d;
	end

	// Tracks whether pin has stayed low since the last entry began
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			low_since_q <= 1'b0;
		else if (start)
			low_since_q <= pin_low;
		else if (!pin_low)
			low_since_q <= 1'b0;
	end

	// Entry starts from pending pin request or allowed trap while running
	assign start = is_running(state_q)
		&& (pend_q || (trap_ok && soft_mgmt_trap_insn)); // see [RQ13]

	// Entry sequencer
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			excmm_pkg::EXCMM_ST_RUN:
				if (start)
					state_d = excmm_pkg::EXCMM_ST_SAVE;
			excmm_pkg::EXCMM_ST_SAVE:
				if (save_cnt_q == 3'(SAVE_CYCLES - 1))
					state_d = excmm_pkg::EXCMM_ST_FETCH; // see [RQ19]
			excmm_pkg::EXCMM_ST_FETCH:
				state_d = excmm_pkg::EXCMM_ST_MGMT;
			excmm_pkg::EXCMM_ST_MGMT:
				if (mgmt_resume_insn)
					state_d = excmm_pkg::EXCMM_ST_RUN;
			default:
				state_d = excmm_pkg::EXCMM_ST_RUN;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			state_q <= excmm_pkg::EXCMM_ST_RUN;
		else
			state_q <= state_d;
	end

	// Header save cycle counter
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			save_cnt_q <= 3'h0;
		else if (state_q == excmm_pkg::EXCMM_ST_SAVE)
			save_cnt_q <= save_cnt_q + 3'h1;
		else
			save_cnt_q <= 3'h0;
	end

	// Registered sequence outputs
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			hdr_save <= 1'b0;
			force_real <= 1'b0;
			fetch_base <= 1'b0;
			system_mgmt_mode <= 1'b0;
		end
		else
		begin
			hdr_save <= state_d == excmm_pkg::EXCMM_ST_SAVE; // see [RQ19]
			force_real <= state_d == excmm_pkg::EXCMM_ST_FETCH;
			fetch_base <= state_d == excmm_pkg::EXCMM_ST_FETCH;
			system_mgmt_mode <= state_d != excmm_pkg::EXCMM_ST_RUN;
		end
	end

	// Arbitration: management first, then non-maskable, then maskable
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			take_mgmt <= 1'b0;
			take_nmi <= 1'b0;
			take_intr <= 1'b0;
		end
		else
		begin
			take_mgmt <= start; // see [RQ12]
			take_nmi <= !start && nmi_req && is_running(state_q);
			take_intr <= !start && !nmi_req && intr_req && is_running(state_q);
		end
	end
endmodule : excmm_top

// ===== dv/excmm_properties.sv
// Port assertions for excmm_top.
// Assumes a single clk_sys domain, bound after the module.
module excmm_properties
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Inputs watched
	input wire logic [7:0] cfg_ctrl_reg_one,
	input wire logic [3:0] mgmt_region_size_reg,
	input wire logic soft_mgmt_trap_insn,
	input wire logic mgmt_resume_insn,
	input wire logic exc_req,
	input wire logic [7:0] exc_vector,
	input wire logic real_mode,
	// Outputs watched
	input wire logic exc_valid,
	input wire logic exc_suppressed,
	input wire logic err_push,
	input wire logic [15:0] err_code,
	input wire logic take_mgmt,
	input wire logic take_nmi,
	input wire logic take_intr,
	input wire logic hdr_save,
	input wire logic force_real,
	input wire logic fetch_base,
	input wire logic system_mgmt_mode
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// Protected mode request and pushing vectors
	wire logic pm = exc_req && !real_mode;
	wire logic pv = exc_vector inside {8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11};
	// Entry steps
	sequence save_s;
		hdr_save [*4];
	endsequence
	sequence jump_s;
		!hdr_save && force_real && fetch_base ##1 !force_real && !fetch_base;
	endsequence
	supp_real_a:
	assert property (exc_req && real_mode && exc_vector inside {8'h0a, 8'h0b, 8'h0e}
		|=> exc_suppressed && !exc_valid) else $error("real fault raised");
	real_nopush_a:
	assert property (exc_req && real_mode |=> !err_push) else $error("real mode push");
	push_set_a:
	assert property (pm && pv |=> err_push && exc_valid) else $error("push missing");
	zero_code_a:
	assert property (pm && exc_vector inside {8'h08, 8'h11} |=> err_code == 16'h0000)
		else $error("code not zero");
	rank_order_a:
	assert property (take_mgmt |-> !take_nmi && !take_intr) else $error("rank broken");
	trap_take_a:
	assert property (soft_mgmt_trap_insn && cfg_ctrl_reg_one[2:1] == 2'h3 && !system_mgmt_mode
		&& mgmt_region_size_reg != 4'h0 |=> take_mgmt && hdr_save) else $error("trap lost");
	entry_seq_a:
	assert property ($rose(hdr_save) |-> system_mgmt_mode throughout (save_s ##1 jump_s))
		else $error("entry order");
	// Resume only counts once saving and the jump are over
	mode_hold_a:
	assert property (system_mgmt_mode && !hdr_save && !force_real
		|=> system_mgmt_mode == !$past(mgmt_resume_insn)) else $error("mode level");
endmodule : excmm_properties

bind excmm_top excmm_properties chk (.*);

// ===== dv/excmm_chipset.sv
// Companion model: stores events, one falling pin edge for each.
// Assumes event pulses on clk_sys; low time in cycles.
module excmm_chipset
(
	// Clock
	input wire logic clk_sys,
	// Events
	input wire logic ev_req,
	input wire logic [7:0] low_cyc,
	// Pin
	output logic mgmt_irq_pin_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int pend = 0;
	// Store events
	always @(posedge clk_sys)
		if (ev_req)
			pend++;
	// One low pulse per stored event
	initial
	begin
		mgmt_irq_pin_n = 1'h1;
		forever
		begin
			@(posedge clk_sys);
			if (pend > 0)
			begin
				pend--;
				#1 mgmt_irq_pin_n = 1'h0;
				repeat (low_cyc) @(posedge clk_sys);
				#1 mgmt_irq_pin_n = 1'h1;
				repeat (4) @(posedge clk_sys);
			end
		end
	end
endmodule : excmm_chipset

// ===== dv/test_excmm_top.sv
// Bench for excmm_top: exception results via a queue, entries via waits.
// Assumes the chipset model and bound checker are compiled first.
module test_excmm_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic [7:0] cfg = 8'h00;
	logic [3:0] size = 4'h0;
	logic trap = 1'h0, resume = 1'h0, memt = 1'h0, iot = 1'h0, nmi = 1'h0, intr = 1'h0;
	logic ev = 1'h0, ereq = 1'h0, rm = 1'h0, tind = 1'h0, inh = 1'h0, tflt = 1'h0;
	logic pfp = 1'h0, pfw = 1'h0, pfu = 1'h0;
	logic [7:0] vec = 8'h00, low = 8'h3c, vo;
	logic [12:0] sel = 13'h0000;
	logic pin_n, vld, sup, psh, tm, tn, ti, mo;
	logic [15:0] eo;
	logic [26:0] expq[$];
	logic [7:0] vl[9] = '{8'h00, 8'h06, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11};
	// Source, config, size, entry wanted
	logic [14:0] gt[10] = '{{2'h0, 8'h06, 4'h1, 1'h1}, {2'h0, 8'h02, 4'h1, 1'h0},
		{2'h0, 8'h04, 4'h1, 1'h0}, {2'h0, 8'h06, 4'h0, 1'h0}, {2'h1, 8'h02, 4'h1, 1'h1},
		{2'h2, 8'h02, 4'hf, 1'h1}, {2'h3, 8'h02, 4'h1, 1'h1}, {2'h3, 8'h06, 4'h1, 1'h0},
		{2'h3, 8'h00, 4'h1, 1'h0}, {2'h3, 8'h02, 4'h0, 1'h0}};
	int fails = 0;
	int n_checks = 0;
	excmm_top uut
	(
		.clk_sys(clk_sys), .sys_rst(sys_rst), .mgmt_irq_pin_n(pin_n), .cfg_ctrl_reg_one(cfg),
		.mgmt_region_size_reg(size), .soft_mgmt_trap_insn(trap), .mgmt_resume_insn(resume),
		.mem_region_trap(memt), .io_trap(iot), .nmi_req(nmi), .intr_req(intr), .exc_req(ereq),
		.exc_vector(vec), .real_mode(rm), .sel_index(sel), .table_indicator(tind),
		.in_handler(inh), .pf_protect(pfp), .pf_write(pfw), .pf_user(pfu), .idt_fault(tflt),
		.exc_valid(vld), .exc_vec_out(vo), .exc_suppressed(sup), .err_push(psh), .err_code(eo),
		.take_mgmt(tm), .take_nmi(tn), .take_intr(ti), .hdr_save(), .force_real(), .fetch_base(),
		.system_mgmt_mode(mo)
	);
	excmm_chipset cs (.clk_sys(clk_sys), .ev_req(ev), .low_cyc(low), .mgmt_irq_pin_n(pin_n));
	// Clock
	initial
		forever #2 clk_sys = ~clk_sys;
	// Count and report one comparison
	task automatic cmp(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'h1)
		begin
			fails++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : cmp
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	// Expected {valid, dropped, push, vector, code}
	function automatic logic [26:0] exp_f(input logic [7:0] v, input logic r);
		logic [15:0] c;
		c = 16'h0000;
		if (v == 8'h0e)
			c = {13'h0000, pfp, pfw, pfu};
		else if (v inside {8'h0a, 8'h0b, 8'h0c, 8'h0d})
			c = tflt ? {sel, 2'h1, inh} : {sel, tind, 1'h0, inh};
		if (r && v inside {8'h0a, 8'h0b, 8'h0e})
			return {3'h2, 24'h000000};
		if (r || !(v inside {8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11}))
			return {3'h4, v, 16'h0000};
		return {3'h5, v, c};
	endfunction : exp_f
	// One exception request, random fault details, request held for the next
	task automatic exc(input logic [7:0] v, input logic r);
		#1 vec = v;
		rm = r;
		ereq = 1'h1;
		{sel, tind, inh, pfp, pfw, pfu, tflt} = 19'($urandom);
		expq.push_back(exp_f(v, r));
		@(posedge clk_sys);
	endtask : exc
	// Take the oldest note when a result shows
	always @(posedge clk_sys)
		if (vld === 1'h1 || sup === 1'h1)
		begin
			if (expq.size() == 0)
				cmp(1'h0, "unexpected result");
			else
				cmp({vld, sup, psh, sup ? 8'h00 : vo, eo} === expq.pop_front(), "result");
		end
	// Pulse one entry source for a cycle
	task automatic fire(input logic [1:0] s);
		#1 {trap, memt, iot, ev} = 4'h8 >> s;
		@(posedge clk_sys);
		#1 {trap, memt, iot, ev} = 4'h0;
	endtask : fire
	// Bounded wait for take_mgmt
	task automatic take_w(input int n, input logic want, input string m);
		logic seen;
		seen = 1'h0;
		repeat (n)
		begin
			@(posedge clk_sys);
			seen = seen | (tm === 1'h1);
			if (seen && want)
				break;
		end
		cmp(seen === want, m);
		if (want && !seen)
			tally_and_finish();
	endtask : take_w
	task automatic leave;
		#1 resume = 1'h1;
		@(posedge clk_sys);
		#1 resume = 1'h0;
		@(posedge clk_sys);
		cmp(mo === 1'h0, "mode off");
	endtask : leave
	task automatic try_entry(input logic [14:0] g);
		#1 cfg = g[12:5] | (8'($urandom) & 8'hf9);
		size = g[4:1];
		@(posedge clk_sys);
		fire(g[14:13]);
		take_w(20, g[0], "entry");
		if (g[0])
		begin
			cmp(mo === 1'h1, "mode on");
			repeat (8) @(posedge clk_sys);
			leave();
			// Region and io entries leave the pin high, so resume raises again
			if (g[14:13] == 2'h1 || g[14:13] == 2'h2)
			begin
				take_w(20, 1'h1, "resume re-entry");
				#1 cfg = 8'h00;
				repeat (8) @(posedge clk_sys);
				leave();
			end
		end
		take_w(80, 1'h0, "spurious entry");
	endtask : try_entry
	// Main sequence
	initial
	begin
		void'($urandom(75));
		repeat (6) @(posedge clk_sys);
		#1 sys_rst = 1'h0;
		repeat (4) @(posedge clk_sys);
		for (int k = 0; k < 54; k++)
			exc(vl[k % 9], k[0]);
		#1 ereq = 1'h0;
		repeat (4) @(posedge clk_sys);
		cmp(expq.size() == 0, "results missing");
		#1 {nmi, intr} = 2'h1;
		repeat (2) @(posedge clk_sys);
		cmp(ti === 1'h1 && tn === 1'h0, "intr alone");
		#1 {nmi, intr} = 2'h3;
		repeat (2) @(posedge clk_sys);
		cmp(tn === 1'h1 && ti === 1'h0, "nmi over intr");
		foreach (gt[i])
			try_entry(gt[i]);
		#1 low = 8'h01;
		@(posedge clk_sys);
		try_entry({2'h3, 8'h02, 4'h1, 1'h0});
		#1 low = 8'h03;
		cfg = 8'h02;
		size = 4'h1;
		@(posedge clk_sys);
		fire(2'h3);
		take_w(20, 1'h1, "pin entry");
		repeat (8) @(posedge clk_sys);
		leave();
		take_w(20, 1'h1, "resume entry");
		#1 cfg = 8'h00;
		repeat (8) @(posedge clk_sys);
		leave();
		take_w(40, 1'h0, "gated entry");
		tally_and_finish();
	end
endmodule : test_excmm_top
